// ==== fmst_core.sv ====
/*
  fmst_core: flame monitor relay drive, automatic optical integrity check
  sequencer, sensitivity timers, priority fault encoder and display latches,
  with an Avalon-MM slave for configuration and status.
  Assumes all comparator and switch inputs are already synchronous to mclk_i
  and debounced; relay outputs are high while the relay is energized.
*/
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
// Contract
// RQ1 - fire signal energizes instant relay and its lamp at once.
// RQ2 - timed relay and lamp only after fire holds unbroken for the delay.
// RQ3 - fire dropping early clears delay count; timing restarts from zero.
// RQ4 - delay configurable 0.2 to 12 seconds, default 5 seconds.
// RQ5 - self-test runs continuously, each detector about six times a minute.
// RQ6 - select, light lamp, await return, lamp off, await end, advance.
// RQ7 - self-test comparator 1 means no UV, 0 means some UV.
// RQ8 - stuck fault when comparator stays 0 three seconds or longer.
// RQ9 - no-response fault when comparator stays 1 beyond sensitivity period.
// RQ10 - on UV, lamp off and next selected; light it once UV gone.
// RQ11 - after last configured detector wrap to first, forever unless bypass.
// RQ12 - fault drops relay, lights trouble lamp, shows code and detector.
// RQ13 - display priority 7,6,5,4,3,2,1,0, then 8.
// RQ14 - encoder takes eight fault lines, gives 3-bit highest active code.
// RQ15 - inputs: four wiring, two sensitivity timers, integrator, inverter.
// RQ16 - any active fault drops fault relay and feeds code display.
// RQ17 - no active fault line displays 8, the lowest priority.
// RQ18 - display enabled only with relay dropped; holds digit in run.
// RQ19 - first fault code stays latched until bypass entered.
// RQ20 - bypass shows highest active fault, stepping down as faults clear.
// RQ21 - no-response fault shows currently selected detector number.
// RQ22 - reset button re-energizes fault relay after fault or system test.
// RQ23 - bypass disables relays, stops self-test, lights lamp and digits.
`timescale 1ns/1ps
`default_nettype none

module fmst_core
  import fmst_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DFLT
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // avalon-mm slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // analog front end comparators
  input wire logic fire_i,
  input wire logic test_cmp_i,
  input wire logic [3:0] wiring_fault_i,
  input wire logic integ_fault_i,
  input wire logic power_fault_i,
  // front panel switches
  input wire logic bypass_i,
  input wire logic reset_btn_i,
  // relays and lamps
  output logic instant_relay_o,
  output logic immediate_output_lamp_o,
  output logic timed_relay_o,
  output logic delayed_output_lamp_o,
  output logic fault_relay_o,
  output logic trouble_lamp_o,
  // optical integrity check lamps
  output logic [2:0] optical_integrity_check_sel_o,
  output logic optical_integrity_check_lamp_o,
  // two-digit display
  output fmst_digit_s det_digit_o,
  output fmst_digit_s fault_digit_o
);

  // highest active fault line, or 8 when none
  function automatic logic [3:0] fmst_penc(input logic [7:0] lines);
    logic [3:0] code;
    code = CODE_NONE; // [RQ17]
    for (int i = 0; i < 8; i++) begin
      if (lines[i]) begin
        code = {1'b0, 3'(i)}; // [RQ13] [RQ14]
      end
    end
    return code;
  endfunction : fmst_penc

  // dwell between detectors so a full sweep takes about ten seconds
  function automatic logic [10:0] fmst_dwell(input logic [2:0] ndet_m1);
    logic [10:0] t;
    case (ndet_m1)
      3'h0: t = 11'(SWEEP_TICKS / 1);
      3'h1: t = 11'(SWEEP_TICKS / 2);
      3'h2: t = 11'(SWEEP_TICKS / 3);
      3'h3: t = 11'(SWEEP_TICKS / 4);
      3'h4: t = 11'(SWEEP_TICKS / 5);
      3'h5: t = 11'(SWEEP_TICKS / 6);
      3'h6: t = 11'(SWEEP_TICKS / 7);
      default: t = 11'(SWEEP_TICKS / 8);
    endcase
    return t;
  endfunction : fmst_dwell

  function automatic logic [11:0] fmst_noresp(input logic [1:0] sens);
    logic [11:0] t;
    case (sens)
      2'h0: t = 12'(NORESP0_MS / TICK_MS);
      2'h1: t = 12'(NORESP1_MS / TICK_MS);
      2'h2: t = 12'(NORESP2_MS / TICK_MS);
      default: t = 12'(NORESP3_MS / TICK_MS);
    endcase
    return t;
  endfunction : fmst_noresp

  // state
  fmst_cfg_s cfg_reg, cfg_next;
  logic [19:0] tick_pre_reg;
  logic [19:0] fire_pre_reg;
  logic [10:0] fire_cnt_reg;
  logic [11:0] stuck_cnt_reg;
  logic [11:0] noresp_cnt_reg;
  logic [10:0] dwell_cnt_reg;
  logic stuck_flt_reg;
  logic noresp_flt_reg;
  fmst_seq_e seq_reg;
  logic [2:0] sel_reg;
  logic latch_reg;
  logic held_reg;
  // sequencer next values
  fmst_seq_e seq_next;
  logic [2:0] sel_next;
  logic [10:0] dwell_next;
  logic lamp_next;

  // decode
  wire tick = (tick_pre_reg == 20'(TICK_CYCLES - 1));
  wire fire_tick = (fire_pre_reg == 20'(TICK_CYCLES - 1));
  wire uv_seen = ~test_cmp_i; // [RQ7]
  wire [7:0] flt_lines = {integ_fault_i, wiring_fault_i, noresp_flt_reg, power_fault_i, stuck_flt_reg}; // [RQ15]
  wire fault_any = |flt_lines;
  wire [3:0] live_code = fmst_penc(flt_lines);
  wire [3:0] sel_num = {1'b0, sel_reg} + 4'h1;
  wire last_det = (sel_reg >= cfg_reg.ndet_m1);
  wire [2:0] sel_adv = last_det ? 3'h0 : sel_reg + 3'h1; // [RQ11]
  wire timed_due = fire_i && (fire_cnt_reg >= cfg_reg.delay);
  wire [11:0] noresp_lim = fmst_noresp(cfg_reg.sens);
  wire [10:0] dwell_lim = fmst_dwell(cfg_reg.ndet_m1);
  wire bus_req = avs_read_i | avs_write_i;
  wire bus_take = bus_req & avs_waitrequest_o;
  wire cfg_wr = avs_write_i & ~avs_waitrequest_o & (avs_address_i == CFG_OFS);
  wire [31:0] be_mask;
  wire [31:0] cfg_word = {14'h0, cfg_reg.sens, 1'b0, cfg_reg.ndet_m1, 1'b0, cfg_reg.delay};
  wire [31:0] cfg_merged = (cfg_word & ~be_mask) | (avs_writedata_i & be_mask);
  wire [10:0] delay_wr = cfg_merged[CFG_DELAY_LSB +: 11];
  wire [31:0] stat_word = {8'h0, flt_lines, optical_integrity_check_lamp_o, optical_integrity_check_sel_o,
                           det_digit_o.value, fault_digit_o.value, bypass_i, fault_relay_o,
                           timed_relay_o, instant_relay_o};
  wire [31:0] rd_mux = (avs_address_i == CFG_OFS) ? cfg_word :
                       (avs_address_i == STAT_OFS) ? stat_word : 32'h0;
  // relay, sensitivity timer and display decode, so the register blocks below stay plain
  wire inst_drive = fire_i & ~bypass_i;
  wire timed_drive = timed_due & ~bypass_i;
  wire relay_drop = latch_reg | fault_any | bypass_i;
  wire noresp_armed = !uv_seen && (seq_reg == SEQ_LIGHT);
  wire show_run = latch_reg | fault_any;
  wire det_shown = (live_code == CODE_NORESP);

  // one mask byte per write lane
  for (genvar g = 0; g < 4; g++) begin : g_lane
    assign be_mask[8*g +: 8] = {8{avs_byteenable_i[g]}};
  end

  // config write: delay clamped into its legal range
  always_comb begin
    cfg_next = cfg_reg;
    if (cfg_wr) begin
      cfg_next.sens = cfg_merged[CFG_SENS_LSB +: 2];
      cfg_next.ndet_m1 = cfg_merged[CFG_NDET_LSB +: 3];
      cfg_next.delay = (delay_wr < DELAY_MIN_TICKS) ? DELAY_MIN_TICKS :
                       (delay_wr > DELAY_MAX_TICKS) ? DELAY_MAX_TICKS : delay_wr; // [RQ4]
    end
  end

  // bus slave: one wait cycle, write lands when waitrequest is seen low
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cfg_reg <= CFG_RESET;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      cfg_reg <= cfg_next;
      avs_waitrequest_o <= ~bus_take;
      if (bus_take) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end

  // shared 10 ms timebase for test timers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tick_pre_reg <= 20'h0;
    end else begin
      tick_pre_reg <= tick ? 20'h0 : tick_pre_reg + 20'h1;
    end
  end

  // fire timing has its own prescaler so a new fire starts a full delay
  always_ff @(posedge mclk_i) begin
    if (reset_i || !fire_i) begin
      fire_pre_reg <= 20'h0; // [RQ3]
      fire_cnt_reg <= 11'h0; // [RQ3]
    end else begin
      fire_pre_reg <= fire_tick ? 20'h0 : fire_pre_reg + 20'h1;
      if (fire_tick && fire_cnt_reg != DELAY_MAX_TICKS) begin
        fire_cnt_reg <= fire_cnt_reg + 11'h1; // [RQ2]
      end
    end
  end

  // relay drive; bypass isolates the loads
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      instant_relay_o <= 1'b0;
      immediate_output_lamp_o <= 1'b0;
      timed_relay_o <= 1'b0;
      delayed_output_lamp_o <= 1'b0;
      fault_relay_o <= 1'b0;
      trouble_lamp_o <= 1'b1;
    end else begin
      instant_relay_o <= inst_drive; // [RQ1] [RQ23]
      immediate_output_lamp_o <= inst_drive; // [RQ1]
      timed_relay_o <= timed_drive; // [RQ2] [RQ23]
      delayed_output_lamp_o <= timed_drive; // [RQ2]
      fault_relay_o <= ~relay_drop; // [RQ12] [RQ16] [RQ23]
      trouble_lamp_o <= relay_drop; // [RQ12] [RQ23]
    end
  end

  // fault latch: a new fault wins over a reset press in the same cycle
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      latch_reg <= 1'b1;
    end else if (fault_any || bypass_i) begin
      latch_reg <= 1'b1; // [RQ16]
    end else if (reset_btn_i) begin
      latch_reg <= 1'b0; // [RQ22]
    end
  end

  // sensitivity timers
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      stuck_cnt_reg <= 12'h0;
      noresp_cnt_reg <= 12'h0;
      stuck_flt_reg <= 1'b0;
      noresp_flt_reg <= 1'b0;
    end else begin
      if (!uv_seen) begin
        stuck_cnt_reg <= 12'h0;
      end else if (tick && stuck_cnt_reg != STUCK_TICKS) begin
        stuck_cnt_reg <= stuck_cnt_reg + 12'h1;
      end
      stuck_flt_reg <= uv_seen && (stuck_cnt_reg >= STUCK_TICKS); // [RQ8]
      // only a lit lamp expects a return; dark dwell is not a miss
      if (!noresp_armed) begin
        noresp_cnt_reg <= 12'h0;
      end else if (tick && noresp_cnt_reg != 12'hFFF) begin
        noresp_cnt_reg <= noresp_cnt_reg + 12'h1;
      end
      noresp_flt_reg <= noresp_armed && (noresp_cnt_reg > noresp_lim); // [RQ9]
    end
  end

  // test lamp sequencer: a lamp is only lit from a dark, settled comparator
  always_comb begin
    seq_next = seq_reg;
    sel_next = sel_reg;
    dwell_next = dwell_cnt_reg;
    lamp_next = optical_integrity_check_lamp_o;
    if (bypass_i) begin
      seq_next = SEQ_IDLE; // [RQ23]
      lamp_next = 1'b0;
    end else begin
      case (seq_reg)
        SEQ_IDLE: begin
          seq_next = SEQ_DARK; // [RQ5]
          if (last_det && sel_reg != cfg_reg.ndet_m1) begin
            sel_next = 3'h0;
          end
        end
        SEQ_LIGHT: begin
          lamp_next = 1'b1; // [RQ6]
          if (uv_seen) begin
            lamp_next = 1'b0; // [RQ10]
            sel_next = sel_adv; // [RQ10] [RQ11]
            seq_next = SEQ_DARK;
          end
        end
        SEQ_DARK: begin
          lamp_next = 1'b0;
          dwell_next = 11'h0;
          if (!uv_seen) begin
            seq_next = SEQ_DWELL; // [RQ6] [RQ10]
          end
        end
        SEQ_DWELL: begin
          if (uv_seen) begin
            seq_next = SEQ_DARK;
          end else if (dwell_cnt_reg >= dwell_lim) begin
            lamp_next = 1'b1; // [RQ6]
            seq_next = SEQ_LIGHT;
          end else if (tick) begin
            dwell_next = dwell_cnt_reg + 11'h1; // [RQ5]
          end
        end
        default: begin
          seq_next = SEQ_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      seq_reg <= SEQ_IDLE;
      sel_reg <= 3'h0;
      dwell_cnt_reg <= 11'h0;
      optical_integrity_check_lamp_o <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      sel_reg <= sel_next;
      dwell_cnt_reg <= dwell_next;
      optical_integrity_check_lamp_o <= lamp_next;
    end
  end

  // registered copy of the selection; it settles long before the lamp lights
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      optical_integrity_check_sel_o <= 3'h0;
    end else begin
      optical_integrity_check_sel_o <= sel_reg;
    end
  end

  // display: live in bypass, first code frozen in run while relay dropped
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      held_reg <= 1'b0;
      fault_digit_o <= '{on: 1'b0, value: CODE_NONE};
      det_digit_o <= '{on: 1'b0, value: 4'h0};
    end else if (bypass_i) begin
      held_reg <= 1'b0; // [RQ19]
      fault_digit_o <= '{on: 1'b1, value: live_code}; // [RQ20] [RQ23]
      det_digit_o <= '{on: 1'b1, value: sel_num}; // [RQ23]
    end else if (show_run) begin
      if (!held_reg) begin
        held_reg <= 1'b1; // [RQ18] [RQ19]
        fault_digit_o <= '{on: 1'b1, value: live_code}; // [RQ12]
        det_digit_o <= '{on: det_shown, value: sel_num}; // [RQ21]
      end
    end else begin
      held_reg <= 1'b0;
      fault_digit_o <= '{on: 1'b0, value: CODE_NONE}; // [RQ18]
      det_digit_o <= '{on: 1'b0, value: 4'h0};
    end
  end

endmodule : fmst_core

`default_nettype wire

// ==== fmst_pkg.sv ====
/*
  fmst_pkg: constants, register layout, states and carrier structs for the
  flame monitor self-test and fault logic.
  Assumes a 100 MHz system clock and a 10 ms timebase tick made in the core.
*/
`default_nettype none

package fmst_pkg;

  // clock and timebase
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES_DFLT = TICK_MS * (CLK_HZ / 1000);

  // timed output delay, in ms as configured, held in ticks
  localparam int unsigned DELAY_MIN_MS = 200;
  localparam int unsigned DELAY_MAX_MS = 12_000;
  localparam int unsigned DELAY_DFLT_MS = 5_000;
  localparam logic [10:0] DELAY_MIN_TICKS = 11'(DELAY_MIN_MS / TICK_MS);
  localparam logic [10:0] DELAY_MAX_TICKS = 11'(DELAY_MAX_MS / TICK_MS);
  localparam logic [10:0] DELAY_DFLT_TICKS = 11'(DELAY_DFLT_MS / TICK_MS);

  // stuck detector: comparator low this long or longer
  localparam int unsigned STUCK_TIME_MS = 3_000;
  localparam logic [11:0] STUCK_TICKS = 12'((STUCK_TIME_MS + TICK_MS - 1) / TICK_MS);

  // no-response limits per sensitivity setting
  localparam int unsigned NORESP0_MS = 1_000;
  localparam int unsigned NORESP1_MS = 2_000;
  localparam int unsigned NORESP2_MS = 3_000;
  localparam int unsigned NORESP3_MS = 4_000;

  // one full sweep of all detectors takes about ten seconds
  localparam int unsigned SWEEP_MS = 10_000;
  localparam int unsigned SWEEP_TICKS = SWEEP_MS / TICK_MS;

  // register byte offsets
  localparam logic [3:0] CFG_OFS = 4'h0;
  localparam logic [3:0] STAT_OFS = 4'h4;

  // config field positions
  localparam int unsigned CFG_DELAY_LSB = 0;
  localparam int unsigned CFG_NDET_LSB = 12;
  localparam int unsigned CFG_SENS_LSB = 16;
  localparam logic [2:0] NDET_M1_DFLT = 3'h7;
  localparam logic [1:0] SENS_DFLT = 2'h0;

  // fault codes
  localparam logic [3:0] CODE_NORESP = 4'h2;
  localparam logic [3:0] CODE_NONE = 4'h8;

  typedef struct packed {
    logic [1:0] sens;
    logic [2:0] ndet_m1;
    logic [10:0] delay;
  } fmst_cfg_s;

  localparam fmst_cfg_s CFG_RESET = '{sens: SENS_DFLT, ndet_m1: NDET_M1_DFLT, delay: DELAY_DFLT_TICKS};

  typedef struct packed {
    logic on;
    logic [3:0] value;
  } fmst_digit_s;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_LIGHT = 2'b01,
    SEQ_DARK = 2'b10,
    SEQ_DWELL = 2'b11
  } fmst_seq_e;

endpackage : fmst_pkg

`default_nettype wire

// ==== fmst_assertions.sv ====
/*
  fmst_assertions: port-level checker for fmst_core, bound into it.
  Assumes synchronous active-high reset and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module fmst_assertions
  import fmst_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // bus handshake
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  // front end and switches
  input wire logic fire_i,
  input wire logic test_cmp_i,
  input wire logic [3:0] wiring_fault_i,
  input wire logic integ_fault_i,
  input wire logic power_fault_i,
  input wire logic bypass_i,
  // outputs watched
  input wire logic instant_relay_o,
  input wire logic timed_relay_o,
  input wire logic fault_relay_o,
  input wire logic trouble_lamp_o,
  input wire logic optical_integrity_check_lamp_o,
  input wire fmst_digit_s det_digit_o,
  input wire fmst_digit_s fault_digit_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_bypass_held;
    bypass_i [*3];
  endsequence

  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer not one cycle");
  property p_inst_on;
    fire_i && !bypass_i |=> instant_relay_o;
  endproperty
  a_inst_on: assert property (p_inst_on) else $error("instant relay late");
  property p_inst_off;
    !fire_i || bypass_i |=> !instant_relay_o;
  endproperty
  a_inst_off: assert property (p_inst_off) else $error("instant relay without fire");
  property p_timed_rise;
    $rose(timed_relay_o) |-> instant_relay_o && $past(fire_i);
  endproperty
  a_timed_rise: assert property (p_timed_rise) else $error("timed relay without fire");
  property p_timed_drop;
    !fire_i |-> ##[1:2] !timed_relay_o;
  endproperty
  a_timed_drop: assert property (p_timed_drop) else $error("timed relay held after fire dropped");
  property p_trouble;
    trouble_lamp_o == !fault_relay_o && (!$fell(fault_relay_o) || fault_digit_o.on);
  endproperty
  a_trouble: assert property (p_trouble) else $error("trouble lamp disagrees with relay");
  property p_fault_drop;
    integ_fault_i || power_fault_i || (|wiring_fault_i) |-> ##[1:2] !fault_relay_o;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("fault relay held on fault");
  property p_bypass;
    s_bypass_held |-> !instant_relay_o && !timed_relay_o && !fault_relay_o && det_digit_o.on && fault_digit_o.on;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass outputs wrong");
  property p_code7;
    (bypass_i && integ_fault_i) [*3] |-> fault_digit_o.value == 4'h7;
  endproperty
  a_code7: assert property (p_code7) else $error("top priority code not shown");
  property p_dark;
    fault_relay_o && $past(fault_relay_o) |-> !fault_digit_o.on && !det_digit_o.on;
  endproperty
  a_dark: assert property (p_dark) else $error("display lit while healthy");
  property p_lamp_off;
    optical_integrity_check_lamp_o && !test_cmp_i |-> ##[1:3] !optical_integrity_check_lamp_o;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("test lamp kept on after return");
  property p_lamp_on;
    $rose(optical_integrity_check_lamp_o) |-> $past(test_cmp_i);
  endproperty
  a_lamp_on: assert property (p_lamp_on) else $error("test lamp lit during return");
endmodule : fmst_assertions

bind fmst_core fmst_assertions i_fmst_assertions (.mclk_i(mclk_i), .reset_i(reset_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .fire_i(fire_i), .test_cmp_i(test_cmp_i),
  .wiring_fault_i(wiring_fault_i), .integ_fault_i(integ_fault_i), .power_fault_i(power_fault_i),
  .bypass_i(bypass_i), .instant_relay_o(instant_relay_o), .timed_relay_o(timed_relay_o),
  .fault_relay_o(fault_relay_o), .trouble_lamp_o(trouble_lamp_o),
  .optical_integrity_check_lamp_o(optical_integrity_check_lamp_o), .det_digit_o(det_digit_o),
  .fault_digit_o(fault_digit_o));

`default_nettype wire

// ==== fmst_partner.sv ====
/*
  fmst_partner: detector seen through the self-test comparator.
  Assumes the lamp drive is synchronous; mode 1 never returns, mode 2 is stuck seeing UV.
*/
`timescale 1ns/1ps
`default_nettype none

module fmst_partner (
  // clock
  input wire logic mclk_i,
  // lamp drive and behaviour
  input wire logic lamp_i,
  input wire logic [1:0] mode_i,
  input wire logic [7:0] lat_i,
  // comparator level
  output logic test_cmp_o
);
  int cnt = 0;
  logic uv = 1'b0;
  // return follows the lamp after lat_i cycles, both ways
  always @(posedge mclk_i) begin
    cnt <= (lamp_i != uv) ? cnt + 1 : 0;
    if (lamp_i != uv && cnt >= lat_i) begin
      uv <= lamp_i;
      cnt <= 0;
    end
  end
  assign test_cmp_o = (mode_i == 2'h2) ? 1'b0 : (mode_i == 2'h1) ? 1'b1 : !uv;
endmodule : fmst_partner

`default_nettype wire

// ==== tb.sv ====
/*
  tb: self-checking bench for fmst_core with a detector partner model.
  Assumes TICK_CYCLES of 10, so one tick is 10 clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  import fmst_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [3:0] avs_address_i = 4'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic fire_i = 1'b0;
  logic test_cmp_i;
  logic [3:0] wiring_fault_i = 4'h0;
  logic integ_fault_i = 1'b0;
  logic power_fault_i = 1'b0;
  logic bypass_i = 1'b0;
  logic reset_btn_i = 1'b0;
  logic instant_relay_o, imm_lamp, timed_relay_o, del_lamp, fault_relay_o, trouble_lamp_o, lamp;
  logic [2:0] sel;
  fmst_digit_s det_digit_o, fault_digit_o;
  logic [1:0] mode = 2'h0;
  logic [7:0] lat = 8'h4;
  logic [31:0] q;
  logic [5:0] m;
  int fails = 0;
  int samples_checked = 0;
  int k, j, e, s0;
  longint t0;
  int exp_q[$];

  always #5 mclk_i = ~mclk_i;

  fmst_core #(.TICK_CYCLES(10)) i_fmst_core (.mclk_i(mclk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .fire_i(fire_i), .test_cmp_i(test_cmp_i), .wiring_fault_i(wiring_fault_i), .integ_fault_i(integ_fault_i),
    .power_fault_i(power_fault_i), .bypass_i(bypass_i), .reset_btn_i(reset_btn_i),
    .instant_relay_o(instant_relay_o), .immediate_output_lamp_o(imm_lamp), .timed_relay_o(timed_relay_o),
    .delayed_output_lamp_o(del_lamp), .fault_relay_o(fault_relay_o), .trouble_lamp_o(trouble_lamp_o),
    .optical_integrity_check_sel_o(sel), .optical_integrity_check_lamp_o(lamp),
    .det_digit_o(det_digit_o), .fault_digit_o(fault_digit_o));
  fmst_partner i_fmst_partner (.mclk_i(mclk_i), .lamp_i(lamp), .mode_i(mode), .lat_i(lat), .test_cmp_o(test_cmp_i));

  task final_report;
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  task chk_bit(input string nm, input logic ex, input logic got);
    samples_checked++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s exp %b got %b", nm, ex, got);
    end
  endtask : chk_bit
  task chk_word(input string nm, input logic [31:0] ex, input logic [31:0] got);
    samples_checked++;
    if (got !== ex) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, ex, got);
    end
  endtask : chk_word
  task cyc(input int c);
    repeat (c) @(posedge mclk_i);
  endtask : cyc
  // request stands until the edge that samples waitrequest low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge mclk_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 20);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    if (t >= 20) begin
      fails++;
      final_report();
    end
  endtask : bus
  task automatic wait_for(ref logic s, input logic v, input int lim);
    int t = 0;
    while (s !== v && t < lim) begin
      @(posedge mclk_i);
      t++;
    end
    if (t >= lim) begin
      fails++;
      final_report();
    end
  endtask : wait_for
  task press;
    reset_btn_i <= 1'b1;
    cyc(3);
    reset_btn_i <= 1'b0;
    cyc(5);
  endtask : press

  initial begin
    void'($urandom(32'hD2703DE6));
    cyc(5);
    reset_i <= 1'b0;
    cyc(2);
    press();
    chk_bit("fault_relay", 1'b1, fault_relay_o);
    chk_bit("fault_digit_on", 1'b0, fault_digit_o.on);
    bus(1'b0, CFG_OFS, 32'h0);
    chk_word("cfg_reset", 32'h0000_71F4, q);
    bus(1'b1, CFG_OFS, 32'h0000_7005);
    bus(1'b0, CFG_OFS, 32'h0);
    chk_word("cfg_min", 32'h0000_7014, q);
    bus(1'b1, CFG_OFS, 32'h0000_7FFF);
    bus(1'b0, CFG_OFS, 32'h0);
    chk_word("cfg_max", 32'h0000_74B0, q);
    bus(1'b0, 4'hC, 32'h0);
    chk_word("unmapped", 32'h0, q);
    bus(1'b1, CFG_OFS, 32'h0000_7014);
    // broken fire first: timing must restart, 200 clocks of delay
    k = $urandom_range(150, 50);
    fire_i <= 1'b1;
    cyc(2);
    chk_bit("instant", 1'b1, instant_relay_o);
    chk_bit("instant_lamp", 1'b1, imm_lamp);
    cyc(k);
    fire_i <= 1'b0;
    cyc(3);
    fire_i <= 1'b1;
    cyc(195);
    chk_bit("timed_early", 1'b0, timed_relay_o);
    cyc(15);
    chk_bit("timed", 1'b1, timed_relay_o);
    chk_bit("timed_lamp", 1'b1, del_lamp);
    fire_i <= 1'b0;
    lat <= 8'($urandom_range(20, 1));
    wait_for(lamp, 1'b0, 3000);
    wait_for(lamp, 1'b1, 3000);
    s0 = sel;
    t0 = $time;
    for (k = 1; k <= 8; k++)
      exp_q.push_back((s0 + k) % 8);
    while (exp_q.size() > 0) begin
      wait_for(lamp, 1'b0, 3000);
      wait_for(lamp, 1'b1, 3000);
      chk_word("sel", 32'(exp_q.pop_front()), 32'(sel));
    end
    chk_bit("sweep", 1'b1, ($time - t0) / 10 inside {[9500:11000]});
    mode <= 2'h1;
    cyc(900);
    chk_bit("noresp_early", 1'b1, fault_relay_o);
    wait_for(fault_relay_o, 1'b0, 400);
    chk_word("noresp_code", 32'(CODE_NORESP), 32'(fault_digit_o.value));
    chk_word("noresp_det", 32'(s0) + 1, 32'(det_digit_o.value));
    mode <= 2'h0;
    integ_fault_i <= 1'b1;
    cyc(10);
    chk_word("latched", 32'(CODE_NORESP), 32'(fault_digit_o.value));
    bypass_i <= 1'b1;
    cyc(5);
    chk_bit("bypass_lamp", 1'b0, lamp);
    chk_bit("trouble", 1'b1, trouble_lamp_o);
    for (k = 0; k < 24; k++) begin
      m = (k == 0) ? 6'h0 : 6'($urandom_range(63, 0));
      {integ_fault_i, wiring_fault_i, power_fault_i} <= m;
      cyc(4);
      e = 8;
      for (j = 0; j < 6; j++)
        if (m[j])
          e = (j == 0) ? 1 : j + 2;
      chk_word("live_code", 32'(e), 32'(fault_digit_o.value));
    end
    {integ_fault_i, wiring_fault_i, power_fault_i} <= 6'h0;
    bypass_i <= 1'b0;
    cyc(5);
    press();
    chk_bit("relay_back", 1'b1, fault_relay_o);
    mode <= 2'h2;
    cyc(2900);
    chk_bit("stuck_early", 1'b1, fault_relay_o);
    wait_for(fault_relay_o, 1'b0, 400);
    chk_word("stuck_code", 32'h0, 32'(fault_digit_o.value));
    final_report();
  end
endmodule : tb

`default_nettype wire
